// ===== hw/rsf_pkg.sv
// Shared constants, states and carrier types of the relay supervisor fault logic
package rsf_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int MS_PER_S = 1000;
	// Power-on delay, watchdog timeout and reset pulse width in ms
	localparam int POR_MS = 44;
	localparam int WD_MS = 44;
	localparam int WDR_MS = 3;
	// Longest times: rounded down to whole cycles
	localparam int POR_CYC = POR_MS * (CLK_HZ / MS_PER_S);
	localparam int WD_CYC = WD_MS * (CLK_HZ / MS_PER_S);
	localparam int WDR_CYC = WDR_MS * (CLK_HZ / MS_PER_S);
	localparam int TMR_W = 24;

	// ----------------------------------------
	// Pins and fields
	// ----------------------------------------
	localparam int NUM_DRV = 3;
	localparam int SYNC_STAGES = 2;
	// Level of the reset pin while the driver pulls it
	localparam logic RESET_DRIVE_LVL = 1'h0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [6:0] {
		ST_SLEEP = 7'h01,
		ST_HOLD = 7'h02,
		ST_POR = 7'h04,
		ST_ARMED = 7'h08,
		ST_RUN = 7'h10,
		ST_ALM_LOW = 7'h20,
		ST_ALM_HIGH = 7'h40
	} rsf_state_t;

	// Asynchronous pin inputs, synchronised as one word
	typedef struct packed {
		logic logic_enable_in;
		logic battery_side_enable_in;
		logic watchdog_kick_in;
		logic startup_delay_terminal;
		logic watchdog_timing_terminal;
		logic over_temperature_flag;
		logic supply_undervoltage_flag;
		logic [NUM_DRV-1:0] drive_request_in;
		logic [NUM_DRV-1:0] driver_overcurrent_flag;
	} rsf_pins_t;

	// Status seen by the system
	typedef struct packed {
		logic enabled;
		logic watchdog_alarm;
		logic outputs_allowed;
		logic por_running;
	} rsf_status_t;

endpackage : rsf_pkg

// ===== hw/rsf_sync.sv
// Two-stage synchroniser for a word of asynchronous inputs
module rsf_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_bad_width
		$error("rsf_sync: WIDTH must be at least 1");
	end

	// First stage is read only by the second
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta <= '0;
			sync_o <= '0;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end

endmodule : rsf_sync

// ===== hw/rsf_drv_latch.sv
// One low-side driver with its overcurrent shut-off latch
module rsf_drv_latch (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic allow_i,
	input wire logic request_i,
	input wire logic overcurrent_i,
	output logic driver_on_o,
	output logic latched_o
);

	logic next_latched;
	logic next_on;

	// Trip sets, a low request clears; a trip wins over the clear
	assign next_latched = (overcurrent_i && driver_on_o) || (latched_o && request_i);
	// Follows its request only while allowed and not tripped
	assign next_on = allow_i && request_i && !next_latched;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			latched_o <= 1'h0;
			driver_on_o <= 1'h0;
		end else begin
			latched_o <= next_latched;
			driver_on_o <= next_on;
		end
	end

endmodule : rsf_drv_latch

// ===== hw/rsf_supervisor.sv
// Supervisor: enable, watchdog, power-on delay, reset pin and driver gating
// Operation
// - Enabled when either enable input high
// - Both enables low: sleep, rails off
// - Sleep: reset driver off, drivers off
// - Kick edges, either direction, restart timeout
// - Timeout starts reset-pulse discharge interval
// - Missed kick: alarm, pulsed reset train
// - Alarm: all drivers off, reset keeps pulsing
// - Heat and undervoltage hold reset steadily low
// - Supply up: reset held through power-on delay
// - Delay terminal high skips power-on delay
// - Driver follows request when enabled, fault-free
// - Overcurrent latches that driver off only
// - Undervoltage: reset low, drivers off, supply on
// - Undervoltage clear restarts power-on delay
// - Over-temperature: reset, supply off, drivers off
// - Sleep and heat drop the supply
// - Drivers wait for first kick after reset
// - Priority: enable, heat, undervoltage, alarm, overcurrent
module rsf_supervisor #(
	parameter int POR_CYCLES = rsf_pkg::POR_CYC,
	parameter int WD_CYCLES = rsf_pkg::WD_CYC,
	parameter int WDR_CYCLES = rsf_pkg::WDR_CYC
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic logic_enable_in_i,
	input wire logic battery_side_enable_in_i,
	input wire logic watchdog_kick_in_i,
	input wire logic startup_delay_terminal_i,
	input wire logic watchdog_timing_terminal_i,
	input wire logic over_temperature_flag_i,
	input wire logic supply_undervoltage_flag_i,
	input wire logic [rsf_pkg::NUM_DRV-1:0] drive_request_in_i,
	input wire logic [rsf_pkg::NUM_DRV-1:0] driver_overcurrent_flag_i,
	output logic fault_reset_n_o,
	output logic fault_reset_n_oe_o,
	output logic logic_supply_out_o,
	output logic internal_rail_on_o,
	output logic [rsf_pkg::NUM_DRV-1:0] low_side_driver_out_o,
	output logic [rsf_pkg::NUM_DRV-1:0] overcurrent_latched_o,
	output rsf_pkg::rsf_status_t status_o
);

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	localparam int TMR_MAX = (1 << rsf_pkg::TMR_W) - 1;

	if (POR_CYCLES < 1 || POR_CYCLES > TMR_MAX) begin : g_bad_por
		$error("rsf_supervisor: POR_CYCLES out of range");
	end
	if (WD_CYCLES < 1 || WD_CYCLES > TMR_MAX) begin : g_bad_wd
		$error("rsf_supervisor: WD_CYCLES out of range");
	end
	if (WDR_CYCLES < 1 || WDR_CYCLES > TMR_MAX) begin : g_bad_wdr
		$error("rsf_supervisor: WDR_CYCLES out of range");
	end

	localparam logic [rsf_pkg::TMR_W-1:0] POR_LAST = rsf_pkg::TMR_W'(POR_CYCLES - 1);
	localparam logic [rsf_pkg::TMR_W-1:0] WD_LAST = rsf_pkg::TMR_W'(WD_CYCLES - 1);
	localparam logic [rsf_pkg::TMR_W-1:0] WDR_LAST = rsf_pkg::TMR_W'(WDR_CYCLES - 1);

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	rsf_pkg::rsf_pins_t pins_async;
	rsf_pkg::rsf_pins_t pins;

	assign pins_async.logic_enable_in = logic_enable_in_i;
	assign pins_async.battery_side_enable_in = battery_side_enable_in_i;
	assign pins_async.watchdog_kick_in = watchdog_kick_in_i;
	assign pins_async.startup_delay_terminal = startup_delay_terminal_i;
	assign pins_async.watchdog_timing_terminal = watchdog_timing_terminal_i;
	assign pins_async.over_temperature_flag = over_temperature_flag_i;
	assign pins_async.supply_undervoltage_flag = supply_undervoltage_flag_i;
	assign pins_async.drive_request_in = drive_request_in_i;
	assign pins_async.driver_overcurrent_flag = driver_overcurrent_flag_i;

	rsf_sync #(
		.WIDTH($bits(rsf_pkg::rsf_pins_t))
	) u_sync (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.async_i(pins_async),
		.sync_o(pins)
	);

	// ----------------------------------------
	// Condition decode
	// ----------------------------------------
	logic kick_prev;
	wire enabled;
	wire heat_fault;
	wire uv_fault;
	wire supply_fault;
	wire kick_edge;
	wire wd_active;
	wire por_bypass;

	// Single enable term
	assign enabled = pins.logic_enable_in || pins.battery_side_enable_in;
	// Heat outranks undervoltage, both under enable
	assign heat_fault = enabled && pins.over_temperature_flag;
	assign uv_fault = enabled && !heat_fault && pins.supply_undervoltage_flag;
	assign supply_fault = heat_fault || uv_fault;
	// Either transition of the kick input counts
	assign kick_edge = pins.watchdog_kick_in ^ kick_prev;
	// Grounded timing terminal defeats the timeout
	assign wd_active = pins.watchdog_timing_terminal;
	// Delay terminal tied high skips the delay
	assign por_bypass = pins.startup_delay_terminal;

	// ----------------------------------------
	// Sequencer state and shared timer
	// ----------------------------------------
	rsf_pkg::rsf_state_t state;
	rsf_pkg::rsf_state_t next_state;
	logic [rsf_pkg::TMR_W-1:0] tmr;
	logic [rsf_pkg::TMR_W-1:0] next_tmr;

	wire por_done;
	wire wd_done;
	wire wdr_done;
	wire in_armed;
	wire in_run;
	wire in_alm_high;
	wire in_window;
	wire kick_seen;
	wire tmr_restart;

	assign por_done = (tmr == POR_LAST);
	// Charge interval ends the watchdog window
	assign wd_done = wd_active && (tmr == WD_LAST);
	// Discharge interval sets the reset pulse width
	assign wdr_done = (tmr == WDR_LAST);

	// Only the watchdog window states count kicks
	// A kick must not stretch the power-on delay or a reset pulse
	assign in_armed = (state == rsf_pkg::ST_ARMED);
	assign in_run = (state == rsf_pkg::ST_RUN);
	assign in_alm_high = (state == rsf_pkg::ST_ALM_HIGH);
	assign in_window = in_armed || in_run || in_alm_high;
	assign kick_seen = kick_edge && in_window;

	// Timer clears on every state change and every counted kick
	assign tmr_restart = (next_state != state) || kick_seen;

	always_comb begin
		next_state = state;
		if (!enabled) begin
			// No enable: sleep outranks all
			next_state = rsf_pkg::ST_SLEEP;
		end else if (supply_fault) begin
			// Heat or undervoltage hold reset
			next_state = rsf_pkg::ST_HOLD;
		end else begin
			unique case (state)
				rsf_pkg::ST_SLEEP, rsf_pkg::ST_HOLD: begin
					// Supply returns: run the delay unless bypassed
					next_state = por_bypass ? rsf_pkg::ST_ARMED : rsf_pkg::ST_POR;
				end
				rsf_pkg::ST_POR: begin
					if (por_bypass || por_done) begin
						next_state = rsf_pkg::ST_ARMED;
					end
				end
				rsf_pkg::ST_ARMED: begin
					// Outputs wait for the first kick
					if (kick_edge) begin
						next_state = rsf_pkg::ST_RUN;
					end else if (wd_done) begin
						next_state = rsf_pkg::ST_ALM_LOW;
					end
				end
				rsf_pkg::ST_RUN: begin
					if (!kick_edge && wd_done) begin
						next_state = rsf_pkg::ST_ALM_LOW;
					end
				end
				rsf_pkg::ST_ALM_LOW: begin
					// End of the discharge pulse
					if (wdr_done) begin
						next_state = rsf_pkg::ST_ALM_HIGH;
					end
				end
				rsf_pkg::ST_ALM_HIGH: begin
					// A kick ends the alarm, a timeout pulses again
					if (kick_edge) begin
						next_state = rsf_pkg::ST_RUN;
					end else if (wd_done) begin
						next_state = rsf_pkg::ST_ALM_LOW;
					end
				end
				default: begin
					next_state = rsf_pkg::ST_SLEEP;
				end
			endcase
		end
	end

	// Counters restart synchronously, saturate at the top
	always_comb begin
		if (tmr_restart) begin
			next_tmr = '0;
		end else if (tmr == rsf_pkg::TMR_W'(TMR_MAX)) begin
			next_tmr = tmr;
		end else begin
			next_tmr = tmr + rsf_pkg::TMR_W'(1);
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= rsf_pkg::ST_SLEEP;
			tmr <= '0;
			kick_prev <= 1'h0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			kick_prev <= pins.watchdog_kick_in;
		end
	end

	// ----------------------------------------
	// Reset pin and supplies
	// ----------------------------------------
	wire go_hold;
	wire go_por;
	wire go_run;
	wire go_alm_low;
	wire go_alm_high;
	wire next_alarm;
	wire next_reset_drive;
	wire next_supply;

	assign go_hold = (next_state == rsf_pkg::ST_HOLD);
	assign go_por = (next_state == rsf_pkg::ST_POR);
	assign go_run = (next_state == rsf_pkg::ST_RUN);
	assign go_alm_low = (next_state == rsf_pkg::ST_ALM_LOW);
	assign go_alm_high = (next_state == rsf_pkg::ST_ALM_HIGH);
	assign next_alarm = go_alm_low || go_alm_high;

	// Low while held, during the delay, or in an alarm pulse
	// Never driven in sleep
	assign next_reset_drive = go_hold || go_por || go_alm_low;

	// Supply dropped by sleep and heat only
	assign next_supply = enabled && !heat_fault;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fault_reset_n_oe_o <= 1'h0;
			logic_supply_out_o <= 1'h0;
			internal_rail_on_o <= 1'h0;
		end else begin
			fault_reset_n_oe_o <= next_reset_drive;
			logic_supply_out_o <= next_supply;
			internal_rail_on_o <= enabled;
		end
	end

	// Open drain: only ever pulls low
	assign fault_reset_n_o = rsf_pkg::RESET_DRIVE_LVL;

	// ----------------------------------------
	// Low-side drivers
	// ----------------------------------------
	wire drv_allow;

	// Only the kicked, fault-free state drives
	assign drv_allow = go_run;

	for (genvar i = 0; i < rsf_pkg::NUM_DRV; i++) begin : g_drv
		rsf_drv_latch u_drv (
			.core_clk_i(core_clk_i),
			.nrst_i(nrst_i),
			.allow_i(drv_allow),
			.request_i(pins.drive_request_in[i]),
			.overcurrent_i(pins.driver_overcurrent_flag[i]),
			.driver_on_o(low_side_driver_out_o[i]),
			.latched_o(overcurrent_latched_o[i])
		);
	end

	// ----------------------------------------
	// Status
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status_o <= '0;
		end else begin
			status_o.enabled <= enabled;
			status_o.watchdog_alarm <= next_alarm;
			status_o.outputs_allowed <= drv_allow;
			status_o.por_running <= go_por;
		end
	end

endmodule : rsf_supervisor

// ===== verification/rsf_supervisor_properties.sv
// Timing and gating properties of the supervisor ports
module rsf_supervisor_chk #(
	parameter int WD_CYCLES = 50,
	parameter int WDR_CYCLES = 5
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic logic_enable_in_i,
	input wire logic battery_side_enable_in_i,
	input wire logic watchdog_kick_in_i,
	input wire logic over_temperature_flag_i,
	input wire logic supply_undervoltage_flag_i,
	input wire logic [rsf_pkg::NUM_DRV-1:0] drive_request_in_i,
	input wire logic [rsf_pkg::NUM_DRV-1:0] driver_overcurrent_flag_i,
	input wire logic fault_reset_n_oe_o,
	input wire logic logic_supply_out_o,
	input wire logic [rsf_pkg::NUM_DRV-1:0] low_side_driver_out_o,
	input wire logic [rsf_pkg::NUM_DRV-1:0] overcurrent_latched_o,
	input wire rsf_pkg::rsf_status_t status_o
);
	wire logic en = logic_enable_in_i || battery_side_enable_in_i;
	wire logic alm = status_o.watchdog_alarm;
	logic kq;
	int quiet;
	int lowc;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	// ----------------------------------------
	// Kick quiet time and low pulse length
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			kq <= 1'h0;
			quiet <= 0;
			lowc <= 0;
		end else begin
			kq <= watchdog_kick_in_i;
			quiet <= (kq != watchdog_kick_in_i) ? 0 : quiet + 1;
			lowc <= (fault_reset_n_oe_o && alm) ? lowc + 1 : 0;
		end
	end
	property p_sleep;
		(!en) [*5] |-> !fault_reset_n_oe_o && !logic_supply_out_o && low_side_driver_out_o == 3'h0;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep outputs");
	property p_heat;
		(en && over_temperature_flag_i) [*5] |-> fault_reset_n_oe_o && !logic_supply_out_o;
	endproperty
	a_heat: assert property (p_heat) else $error("heat outputs");
	property p_uv;
		(en && !over_temperature_flag_i && supply_undervoltage_flag_i) [*5]
			|-> fault_reset_n_oe_o && logic_supply_out_o && low_side_driver_out_o == 3'h0;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage outputs");
	property p_pulse;
		$fell(fault_reset_n_oe_o) && alm |-> lowc == WDR_CYCLES;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse width");
	property p_alarm_off;
		alm && $past(alm) |-> low_side_driver_out_o == 3'h0;
	endproperty
	a_alarm_off: assert property (p_alarm_off) else $error("drivers on in alarm");
	property p_timeout;
		$rose(alm) |-> quiet >= WD_CYCLES;
	endproperty
	a_timeout: assert property (p_timeout) else $error("early alarm");
	property p_follow;
		(status_o.outputs_allowed && !alm && drive_request_in_i[0] && !overcurrent_latched_o[0]
			&& !driver_overcurrent_flag_i[0]) [*5] |-> low_side_driver_out_o[0];
	endproperty
	a_follow: assert property (p_follow) else $error("driver not following");
	property p_trip;
		overcurrent_latched_o[1] |=> !low_side_driver_out_o[1];
	endproperty
	a_trip: assert property (p_trip) else $error("tripped driver on");
endmodule : rsf_supervisor_chk

bind rsf_supervisor rsf_supervisor_chk #(
	.WD_CYCLES(WD_CYCLES),
	.WDR_CYCLES(WDR_CYCLES)
) u_chk (
	.core_clk_i(core_clk_i),
	.nrst_i(nrst_i),
	.logic_enable_in_i(logic_enable_in_i),
	.battery_side_enable_in_i(battery_side_enable_in_i),
	.watchdog_kick_in_i(watchdog_kick_in_i),
	.over_temperature_flag_i(over_temperature_flag_i),
	.supply_undervoltage_flag_i(supply_undervoltage_flag_i),
	.drive_request_in_i(drive_request_in_i),
	.driver_overcurrent_flag_i(driver_overcurrent_flag_i),
	.fault_reset_n_oe_o(fault_reset_n_oe_o),
	.logic_supply_out_o(logic_supply_out_o),
	.low_side_driver_out_o(low_side_driver_out_o),
	.overcurrent_latched_o(overcurrent_latched_o),
	.status_o(status_o)
);

// ===== verification/rsf_mcu_model.sv
// Microcontroller model: kicks the watchdog while its reset pin reads high
module rsf_mcu_model #(
	parameter int PERIOD = 20
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic reset_pin_i,
	input wire logic kick_en_i,
	output logic kick_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	// Toggle the kick line once every PERIOD cycles
	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			cnt = 0;
			kick_o <= #10 1'h0;
		end else if (!kick_en_i || !reset_pin_i) begin
			cnt = 0;
		end else if (cnt == PERIOD - 1) begin
			cnt = 0;
			kick_o <= #10 ~kick_o;
		end else begin
			cnt = cnt + 1;
		end
	end
endmodule : rsf_mcu_model

// ===== verification/tb_top.sv
// Self-checking testbench of the supervisor
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int POR = 40;
	logic core_clk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic logic_enable_in_i = 1'h0;
	logic battery_side_enable_in_i = 1'h0;
	logic watchdog_kick_in_i;
	logic startup_delay_terminal_i = 1'h0;
	logic watchdog_timing_terminal_i = 1'h1;
	logic over_temperature_flag_i = 1'h0;
	logic supply_undervoltage_flag_i = 1'h0;
	logic [2:0] drive_request_in_i = 3'h0;
	logic [2:0] driver_overcurrent_flag_i = 3'h0;
	logic fault_reset_n_o;
	logic fault_reset_n_oe_o;
	logic logic_supply_out_o;
	logic internal_rail_on_o;
	logic [2:0] low_side_driver_out_o;
	logic [2:0] overcurrent_latched_o;
	rsf_pkg::rsf_status_t status_o;
	logic kick_en = 1'h0;
	logic pv;
	int error_cnt = 0;
	int check_count = 0;
	int n;
	// Pull-up from the logic supply
	wire logic pin = fault_reset_n_oe_o ? fault_reset_n_o : logic_supply_out_o;
	always #50 core_clk_i = ~core_clk_i;
	rsf_supervisor #(.POR_CYCLES(POR), .WD_CYCLES(50), .WDR_CYCLES(5)) DUT (.*);
	rsf_mcu_model #(.PERIOD(20)) u_mcu (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.reset_pin_i(pin), .kick_en_i(kick_en), .kick_o(watchdog_kick_in_i));
	task automatic cy(input int k);
		repeat (k) @(posedge core_clk_i);
		#10;
	endtask : cy
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic por_wait();
		n = 0;
		while (status_o.por_running === 1'h1 && n < 100) begin
			cy(1);
			n++;
		end
	endtask : por_wait
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		cy(2);
		nrst_i = 1'h1;
		chk(8'({fault_reset_n_oe_o, logic_supply_out_o, status_o}), 8'h00);
		battery_side_enable_in_i = 1'h1;
		cy(3);
		chk(8'({status_o.por_running, fault_reset_n_oe_o, internal_rail_on_o}), 8'h07);
		por_wait();
		chk(8'(n), 8'(POR));
		drive_request_in_i = 3'h7;
		cy(10);
		chk(8'(low_side_driver_out_o), 8'h00);
		kick_en = 1'h1;
		cy(30);
		chk(8'(low_side_driver_out_o), 8'h07);
		$display("test startup done");
		driver_overcurrent_flag_i = 3'h2;
		cy(3);
		driver_overcurrent_flag_i = 3'h0;
		cy(3);
		chk(8'({overcurrent_latched_o, low_side_driver_out_o}), 8'h15);
		drive_request_in_i = 3'h5;
		cy(4);
		drive_request_in_i = 3'h7;
		cy(5);
		chk(8'({overcurrent_latched_o, low_side_driver_out_o}), 8'h07);
		$display("test overcurrent done");
		kick_en = 1'h0;
		n = 0;
		while (status_o.watchdog_alarm !== 1'h1 && n < 100) begin
			cy(1);
			n++;
		end
		cy(1);
		chk(8'({status_o.watchdog_alarm, fault_reset_n_oe_o, low_side_driver_out_o}), 8'h18);
		n = 0;
		repeat (130) begin
			pv = fault_reset_n_oe_o;
			cy(1);
			if (!pv && fault_reset_n_oe_o)
				n++;
		end
		chk(8'(n), 8'h02);
		kick_en = 1'h1;
		cy(40);
		chk(8'({status_o.watchdog_alarm, low_side_driver_out_o}), 8'h07);
		$display("test watchdog done");
		supply_undervoltage_flag_i = 1'h1;
		cy(5);
		chk(8'({fault_reset_n_oe_o, logic_supply_out_o, low_side_driver_out_o}), 8'h18);
		supply_undervoltage_flag_i = 1'h0;
		cy(3);
		chk(8'(status_o.por_running), 8'h01);
		por_wait();
		cy(30);
		chk(8'(low_side_driver_out_o), 8'h07);
		$display("test undervoltage done");
		over_temperature_flag_i = 1'h1;
		supply_undervoltage_flag_i = 1'h1;
		cy(5);
		chk(8'({fault_reset_n_oe_o, logic_supply_out_o, low_side_driver_out_o, pin}), 8'h20);
		over_temperature_flag_i = 1'h0;
		supply_undervoltage_flag_i = 1'h0;
		cy(3);
		chk(8'(status_o.por_running), 8'h01);
		por_wait();
		$display("test heat done");
		startup_delay_terminal_i = 1'h1;
		battery_side_enable_in_i = 1'h0;
		over_temperature_flag_i = 1'h1;
		cy(5);
		chk(8'({fault_reset_n_oe_o, logic_supply_out_o, internal_rail_on_o, pin}), 8'h00);
		over_temperature_flag_i = 1'h0;
		logic_enable_in_i = 1'h1;
		cy(3);
		chk(8'({status_o.por_running, fault_reset_n_oe_o, pin}), 8'h01);
		$display("test sleep done");
		// Grounded timing terminal: no kicks and still no alarm
		watchdog_timing_terminal_i = 1'h0;
		kick_en = 1'h0;
		cy(60);
		chk(8'({status_o.watchdog_alarm, fault_reset_n_oe_o, low_side_driver_out_o}), 8'h00);
		$display("test watchdog off done");
		end_of_test();
	end
	initial begin
		#400000;
		error_cnt++;
		end_of_test();
	end
endmodule : tb_top
